// >>> design/dps_host.sv
// Host controller for one port of a dual-port token-flag unit.
// Assumes the device answers within one ref_clk period of output enable going low; data inputs are synchronous.
//
// Behaviour
// [RULE1] A flag read returns its value replicated on every data bit.
// [RULE2] Device latches read value when select and output enable go active.
// [RULE3] Host releases select and output enable between consecutive polling reads.
// [RULE4] Claim writes zero first, then reads back to confirm ownership.
// [RULE5] Device stores a losing zero request while flag still reads one.
// [RULE6] After a failed claim, host keeps polling or writes one to withdraw.
// [RULE7] First zero request owns the flag until that side writes one.
// [RULE8] Release with pending other request hands the token across at once.
// [RULE9] New owner keeps flag low until it writes one.
// [RULE10] Simultaneous zero writes grant the token to exactly one side.
// [RULE11] The earlier requester receives the token.
// [RULE12] For a true tie the device picks either port.
// [RULE13] Flags and request latches are undefined at power-up.
// [RULE14] Start-up writes one to every flag, from each port.
// [RULE15] Select low picks token space; three low address bits pick the flag.
// [RULE16] Only data bit zero carries the written request.
// [RULE17] Zero requests a token, one from the same side releases it.
`timescale 1ns/100ps
module dps_host (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic cmd_valid, // Command request
  input wire dps_pkg::dps_cmd_t cmd, // Command code
  input wire logic [dps_pkg::IDX_W-1:0] cmd_idx, // Flag index
  input wire logic [dps_pkg::CNT_W-1:0] cmd_tries, // Polls after a failed claim, 0 = withdraw
  output logic cmd_ready, // Idle and accepting a command
  output logic resp_valid, // One-cycle answer pulse
  output logic resp_owned, // Flag read low: token held
  output logic resp_err, // Readback bits disagreed
  output logic token_space_select_n, // Token space select, active low
  output logic oe_n, // Output enable, active low
  output logic we_n, // Write strobe, active low
  output logic [dps_pkg::ADDR_W-1:0] addr, // Address to device
  output logic [dps_pkg::DATA_W-1:0] dout, // Data to device
  output logic dout_en, // High while host drives data
  input wire logic [dps_pkg::DATA_W-1:0] din // Data from device
);
  import dps_pkg::*;
  // ==========================================================================
  // Sequencer
  typedef enum logic [2:0] {DPS_IDLE, DPS_WRITE, DPS_GAP, DPS_READ, DPS_DONE} dps_state_t;
  dps_state_t state;
  dps_cmd_t op;
  logic [IDX_W-1:0] idx;
  logic [CNT_W-1:0] tries;
  logic wbit;
  logic after_read;
  logic strobe_start;
  logic strobe_done;
  logic gap_start;
  logic gap_done;
  dps_pins_t pins;
  logic [DATA_W-1:0] rd;
  logic flag_low;
  logic wd_sent;
  // The decision edge is also the capture edge, so the live pin value is used there
  assign flag_low = (state == DPS_READ && !oe_n) ? ~din[0] : ~rd[0];
  dps_strobe #(.CYC(STROBE_CYC)) u_strobe (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(strobe_start),
    .done(strobe_done)
  );
  dps_strobe #(.CYC(GAP_CYC)) u_gap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(gap_start),
    .done(gap_done)
  );
  // Start pulses are derived from state changes so the counters stay in step
  logic cmd_take;
  assign cmd_take = (state == DPS_IDLE) && cmd_valid;
  // Withdraw after a read goes through a write phase
  logic withdraw;
  assign withdraw = (state == DPS_GAP) && gap_done && after_read && (op == DPS_CMD_RELEASE);
  assign strobe_start = cmd_take || ((state == DPS_GAP) && gap_done);
  assign gap_start = strobe_done && (state == DPS_WRITE || state == DPS_READ);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= DPS_IDLE;
      op <= DPS_CMD_PEEK;
      idx <= 3'h0;
      tries <= 4'h0;
      wbit <= 1'b1;
      after_read <= 1'b0;
      wd_sent <= 1'b0;
    end
    else
    begin
      case (state)
        DPS_IDLE:
        begin
          if (cmd_valid)
          begin
            op <= cmd;
            idx <= (cmd == DPS_CMD_INIT) ? 3'h0 : cmd_idx;
            tries <= cmd_tries;
            after_read <= 1'b0;
            wd_sent <= 1'b0;
            // Claim writes zero; release and init write one
            wbit <= (cmd == DPS_CMD_CLAIM) ? 1'b0 : 1'b1; // see [RULE17] see [RULE14]
            state <= (cmd == DPS_CMD_PEEK) ? DPS_READ : DPS_WRITE; // see [RULE4]
          end
        end
        DPS_WRITE:
          if (strobe_done)
            state <= DPS_GAP;
        DPS_GAP:
        begin
          // Gap with select high also gives the device a fresh read edge
          if (gap_done)
          begin
            if (op == DPS_CMD_INIT)
            begin
              if (idx == 3'h7)
                state <= DPS_DONE;
              else
              begin
                idx <= idx + 3'h1; // see [RULE14]
                state <= DPS_WRITE;
              end
            end
            else if (withdraw && !wd_sent)
            begin
              // A single write of one clears our pending request latch
              wd_sent <= 1'b1;
              state <= DPS_WRITE; // see [RULE6]
            end
            else if (after_read)
              state <= (op == DPS_CMD_RELEASE) ? DPS_DONE : DPS_READ; // see [RULE3]
            else
              state <= (op == DPS_CMD_RELEASE) ? DPS_DONE : DPS_READ; // see [RULE4]
          end
        end
        DPS_READ:
        begin
          if (strobe_done)
          begin
            after_read <= 1'b1;
            if (op == DPS_CMD_CLAIM && !flag_low)
            begin
              if (tries != 4'h0)
              begin
                tries <= tries - 4'h1; // see [RULE6]
                state <= DPS_GAP;
              end
              else
              begin
                // Withdraw the pending request so the token is not stranded
                op <= DPS_CMD_RELEASE; // see [RULE6]
                wbit <= 1'b1;
                state <= DPS_GAP;
              end
            end
            else
              state <= DPS_DONE;
          end
        end
        DPS_DONE:
          state <= DPS_IDLE;
        default:
          state <= DPS_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // Pins
  always_comb
  begin
    pins = PINS_IDLE;
    pins.addr = {{(ADDR_W - IDX_W){1'b0}}, idx}; // see [RULE15]
    if (state == DPS_WRITE)
    begin
      pins.cs_n = 1'b0;
      pins.we_n = 1'b0;
      pins.dout = {{(DATA_W - 1){1'b0}}, wbit}; // see [RULE16]
      pins.dout_en = 1'b1;
    end
    else if (state == DPS_READ)
    begin
      pins.cs_n = 1'b0;
      pins.oe_n = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      token_space_select_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      addr <= ADDR_ZERO;
      dout <= 8'hFF;
      dout_en <= 1'b0;
    end
    else
    begin
      token_space_select_n <= pins.cs_n;
      oe_n <= pins.oe_n;
      we_n <= pins.we_n;
      addr <= pins.addr;
      dout <= pins.dout;
      dout_en <= pins.dout_en;
    end
  end
  // ==========================================================================
  // Readback
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd <= 8'hFF;
    else if (state == DPS_READ && !oe_n)
      rd <= din;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_valid <= 1'b0;
      resp_owned <= 1'b0;
      resp_err <= 1'b0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      resp_valid <= (state == DPS_DONE);
      cmd_ready <= (state == DPS_IDLE) && !cmd_valid;
      if (state == DPS_DONE)
      begin
        resp_owned <= after_read && (op != DPS_CMD_RELEASE) && flag_low; // see [RULE4]
        // All bits must agree with bit zero
        resp_err <= after_read && (rd != {DATA_W{rd[0]}}); // see [RULE1]
      end
    end
  end
endmodule

// >>> design/dps_pkg.sv
// Package for the token-flag host controller: pin bundles, commands, timing counts.
// Assumes a 40 MHz ref_clk and a device port driven as a plain asynchronous SRAM.
package dps_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = 25;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // ==========================================================================
  // Geometry
  localparam int FLAG_NUM = 8;
  localparam int IDX_W = 3;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  // ==========================================================================
  // Commands
  typedef enum logic [1:0] {DPS_CMD_CLAIM, DPS_CMD_RELEASE, DPS_CMD_PEEK, DPS_CMD_INIT} dps_cmd_t;
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_en;
  } dps_pins_t;
  localparam dps_pins_t PINS_IDLE = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      addr: 16'h0000, dout: 8'hFF, dout_en: 1'b0};
endpackage

// >>> design/dps_strobe.sv
// Strobe length counter for the host sequencer.
// Assumes start is a one-cycle pulse and done is read back by the caller.
`timescale 1ns/100ps
module dps_strobe #(
  parameter int CYC = 2
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic start, // Begin a timed phase
  output logic done // High in the last cycle of the phase
);
  import dps_pkg::*;
  logic [CNT_W-1:0] cnt;
  logic run;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      run <= 1'b0;
    end
    else if (start)
    begin
      cnt <= CNT_W'(CYC - 1);
      run <= 1'b1;
    end
    else if (run && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else
      run <= 1'b0;
  end
  assign done = run && (cnt == 4'h0);
endmodule

// >>> tb/dps_chk.sv
// Pin sequencing checker for the token-flag host.
// Bound onto dps_host; sees only its ports.
`timescale 1ns/100ps
module dps_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic cmd_valid, // Request
  input wire logic cmd_ready, // Idle
  input wire logic resp_valid, // Answer
  input wire logic token_space_select_n, // Select
  input wire logic oe_n, // Read strobe
  input wire logic we_n, // Write strobe
  input wire logic [dps_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [dps_pkg::DATA_W-1:0] dout, // Data out
  input wire logic dout_en // Drive
);
  import dps_pkg::*;
  wire logic rd = !token_space_select_n && !oe_n;
  wire logic wr = !token_space_select_n && !we_n;
  // ==========================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_ph;
    wr[*2] ##1 token_space_select_n;
  endsequence
  sequence rd_ph;
    rd[*2] ##1 !rd;
  endsequence
  idle_pins_a: assert property (cmd_ready |-> token_space_select_n && oe_n && we_n)
    else $error("strobe active while idle");
  rd_wr_excl_a: assert property (!(rd && !we_n))
    else $error("read and write together");
  wr_drive_a: assert property (wr |-> dout_en)
    else $error("write without data drive");
  addr_high_a: assert property (!token_space_select_n |-> addr[ADDR_W-1:3] == '0)
    else $error("upper address bits set");
  resp_pulse_a: assert property (resp_valid |=> !resp_valid)
    else $error("answer longer than one cycle");
  claim_order_a: assert property ($rose(wr) && !dout[0] |-> wr_ph ##1 rd_ph)
    else $error("claim not write then read");
  poll_gap_a: assert property ($rose(rd) |-> rd_ph)
    else $error("read not released");
  start_bound_a: assert property (cmd_valid && cmd_ready |-> ##[1:3] !token_space_select_n)
    else $error("command never started");
endmodule
bind dps_host dps_chk chk_u (.ref_clk, .rst_n, .cmd_valid, .cmd_ready, .resp_valid,
  .token_space_select_n, .oe_n, .we_n, .addr, .dout, .dout_en);

// >>> tb/dps_dev.sv
// Behavioural token-flag device: left port pins, right side poked by pulse.
// Assumes the bench plays the right-side processor.
`timescale 1ns/100ps
module dps_dev (
  input wire logic sel_n, // Select
  input wire logic oe_n, // Read strobe
  input wire logic we_n, // Write strobe
  input wire logic [15:0] addr, // Address
  input wire logic [7:0] din, // Write data
  output logic [7:0] dout, // Read data
  input wire logic r_we, // Right write
  input wire logic [2:0] r_idx, // Right index
  input wire logic r_bit, // Right bit
  output logic [7:0] r_flags // Right view
);
  logic req [1:2][0:7];
  // Owner 1 left, 2 right, 0 free; left unset at power-up
  logic [1:0] own [0:7];
  logic [7:0] held;
  logic [2:0] w_idx;
  logic w_bit;
  wire logic rd_n = sel_n | oe_n;
  wire logic wr_n = sel_n | we_n;
  task automatic side_wr(input logic [1:0] s, input logic [2:0] i, input logic b);
    req[s][i] = b;
    // First zero wins; a tie is settled by event order
    if (!b && own[i] !== 2'h1 && own[i] !== 2'h2)
      own[i] = s;
    else if (b && own[i] === s)
      own[i] = (req[3 - s][i] === 1'b0) ? 2'h3 - s : 2'h0;
    else if (b && own[i] !== 2'h1 && own[i] !== 2'h2 && req[3 - s][i] === 1'b1)
      own[i] = 2'h0;
  endtask
  // Strobes, address and data launch on one clock edge: sample them once settled
  always @(negedge wr_n)
  begin
    #5;
    w_idx = addr[2:0];
    w_bit = din[0];
  end
  always @(posedge wr_n) side_wr(2'h1, w_idx, w_bit);
  always @(posedge r_we) side_wr(2'h2, r_idx, r_bit);
  always @(negedge rd_n)
  begin
    #5;
    held = (own[addr[2:0]] === 2'h1) ? 8'h00 : 8'hFF;
  end
  assign dout = rd_n ? ~held : held;
  always_comb
    for (int k = 0; k < 8; k++) r_flags[k] = (own[k] !== 2'h2);
endmodule

// >>> tb/dps_host_tb.sv
// Bench: host against the device model; this bench plays the right side.
// Assumes one resp_valid pulse for every command.
`timescale 1ns/100ps
module dps_host_tb;
  import dps_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  dps_cmd_t cmd = DPS_CMD_PEEK;
  logic [IDX_W-1:0] cmd_idx = '0;
  logic [CNT_W-1:0] cmd_tries = '0;
  logic cmd_ready, resp_valid, resp_owned, resp_err, sel_n, oe_n, we_n, dout_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dout, din;
  logic r_we = 1'b0;
  logic [2:0] r_idx = '0;
  logic r_bit = 1'b1;
  logic [7:0] r_flags;
  logic exp_q [$];
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h62;
  dps_host dut_u (.ref_clk, .rst_n, .cmd_valid, .cmd, .cmd_idx, .cmd_tries, .cmd_ready,
    .resp_valid, .resp_owned, .resp_err, .token_space_select_n(sel_n), .oe_n, .we_n, .addr,
    .dout, .dout_en, .din);
  dps_dev dev_u (.sel_n, .oe_n, .we_n, .addr, .din(dout), .dout(din), .r_we, .r_idx, .r_bit,
    .r_flags);
  initial forever #12.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    // An answer still owed means a command hung
    if (exp_q.size() != 0) fails++;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic host(input dps_cmd_t c, input logic [2:0] i, input logic [3:0] t, input logic e);
    for (int w = 0; w < 200 && cmd_ready !== 1'b1; w++) @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_idx = i;
    cmd_tries = t;
    exp_q.push_back(e);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (int w = 0; w < 400 && exp_q.size() > 0; w++) @(negedge ref_clk);
  endtask
  task automatic rw(input logic [2:0] i, input logic b);
    {r_we, r_idx, r_bit} = {1'b1, i, b};
    @(negedge ref_clk);
    r_we = 1'b0;
    @(negedge ref_clk);
  endtask
  always @(negedge ref_clk)
    if (resp_valid === 1'b1)
    begin
      chk("owned", resp_owned, exp_q.pop_front());
      chk("err", resp_err, 8'h00);
    end
  always @(posedge ref_clk)
    if (++cyc == 20000)
    begin
      fails++;
      end_of_test();
    end
  initial
  begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) rw(i, 1'b1);
    host(DPS_CMD_INIT, 0, 0, 0);
    for (int k = 0; k < 4; k++)
    begin
      rng = xs(rng);
      host(DPS_CMD_CLAIM, rng[2:0], rng[7:4], 1);
      host(DPS_CMD_PEEK, rng[2:0], 0, 1);
      chk("right view", r_flags[rng[2:0]], 8'h01);
      host(DPS_CMD_RELEASE, rng[2:0], 0, 0);
    end
    // Right owns flag 5; the host keeps polling while the right side lets go
    rw(5, 1'b0);
    fork
      host(DPS_CMD_CLAIM, 5, 15, 1);
      begin
        repeat (8) @(negedge ref_clk);
        rw(5, 1'b1);
      end
    join
    chk("handover right", r_flags[5], 8'h01);
    host(DPS_CMD_PEEK, 5, 0, 1);
    rw(5, 1'b0);
    chk("pending right", r_flags[5], 8'h01);
    host(DPS_CMD_PEEK, 5, 0, 1);
    host(DPS_CMD_RELEASE, 5, 0, 0);
    chk("handback", r_flags[5], 8'h00);
    host(DPS_CMD_PEEK, 5, 0, 0);
    rw(5, 1'b1);
    chk("freed", r_flags[5], 8'h01);
    // A claim that runs out of polls must leave no pending request behind
    rw(3, 1'b0);
    host(DPS_CMD_CLAIM, 3, 2, 0);
    rw(3, 1'b1);
    chk("withdrawn", r_flags[3], 8'h01);
    host(DPS_CMD_PEEK, 3, 0, 0);
    host(DPS_CMD_RELEASE, 3, 0, 0);
    end_of_test();
  end
endmodule
